// ### hdl/wcthr_pkg.sv
// Constants and types for the window comparator threshold register bank
package wcthr_pkg;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CH4_LOW_UP   = 8'h33;
    localparam logic [7:0] ADDR_CH5_HYST     = 8'h34;
    localparam logic [7:0] ADDR_CH5_HIGH_UP  = 8'h35;
    localparam logic [7:0] ADDR_CH5_COUNT    = 8'h36;
    localparam logic [7:0] ADDR_CH5_LOW_UP   = 8'h37;
    localparam logic [7:0] ADDR_CH6_HYST     = 8'h38;
    localparam logic [7:0] ADDR_CH6_HIGH_UP  = 8'h39;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_LOW_UP        = 8'h00;
    localparam logic [7:0] RST_HYST          = 8'hf0;
    localparam logic [7:0] RST_HIGH_UP       = 8'hff;
    localparam logic [7:0] RST_COUNT         = 8'h00;
    localparam logic [7:0] RD_UNMAPPED       = 8'h00;

    // ------------------------------------------------------------------
    // Field positions: upper nibble holds a limit nibble, lower the setting
    // ------------------------------------------------------------------
    localparam int         NIB_HI_MSB        = 7;
    localparam int         NIB_HI_LSB        = 4;
    localparam int         NIB_LO_MSB        = 3;
    localparam int         NIB_LO_LSB        = 0;
    localparam int         HYST_SHIFT        = 3;
    localparam logic [2:0] HYST_FILL         = 3'h0;
    localparam logic [4:0] HYST_PAD          = 5'h00;
    localparam logic [3:0] CNT_ZERO          = 4'h0;
    localparam logic [3:0] CNT_ONE           = 4'h1;
    localparam logic [11:0] FULL_SCALE       = 12'hfff;
    localparam logic [11:0] ZERO_SCALE       = 12'h000;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } wcthr_regreq_t;

    typedef struct packed {
        logic        valid;
        logic [11:0] data;
    } wcthr_sample_t;

    typedef struct packed {
        logic [7:0] ch4LowUp;
        logic [7:0] ch5Hyst;
        logic [7:0] ch5HighUp;
        logic [7:0] ch5Count;
        logic [7:0] ch5LowUp;
        logic [7:0] ch6Hyst;
        logic [7:0] ch6HighUp;
    } wcthr_regs_t;

    typedef struct packed {
        wcthr_regs_t regs;
        logic [7:0]  rdData;
        logic        rdValid;
    } wcthr_bank_state_t;

    typedef struct packed {
        logic [3:0] cnt;
        logic       flag;
    } wcthr_cmp_state_t;

    localparam wcthr_regs_t REGS_RESET = '{
        ch4LowUp:  RST_LOW_UP,
        ch5Hyst:   RST_HYST,
        ch5HighUp: RST_HIGH_UP,
        ch5Count:  RST_COUNT,
        ch5LowUp:  RST_LOW_UP,
        ch6Hyst:   RST_HYST,
        ch6HighUp: RST_HIGH_UP
    };

endpackage

// ### hdl/wcthr_window_cmp.sv
// Window comparator with hysteresis and beyond-limit event counter that only an inside-window sample restarts
`timescale 1ns/1ps

module wcthr_window_cmp
    import wcthr_pkg::*;
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          sys_rst,
    // Limits and settings
    input  wire logic [11:0]   highLimit,
    input  wire logic [11:0]   lowLimit,
    input  wire logic [3:0]    hystValue,
    input  wire logic [3:0]    countCfg,
    // Samples and flag
    input  wire wcthr_sample_t sample,
    input  wire logic          eventClear,
    output logic               eventFlag
);

    // ------------------------------------------------------------------
    // Hysteresis-adjusted release levels
    // ------------------------------------------------------------------
    logic [11:0]      hystAmt;
    logic [11:0]      highRelease;
    logic [12:0]      lowSum;
    logic [11:0]      lowRelease;
    logic             isAbove;
    logic             isBelow;
    logic             isInside;
    wcthr_cmp_state_t s_q;
    wcthr_cmp_state_t s_d;

    assign hystAmt     = {HYST_PAD, hystValue, HYST_FILL};
    assign highRelease = (highLimit > hystAmt) ? highLimit - hystAmt : ZERO_SCALE;
    assign lowSum      = {1'b0, lowLimit} + {1'b0, hystAmt};
    // Saturate so a large band never wraps into an always-inside window
    assign lowRelease  = lowSum[12] ? FULL_SCALE : lowSum[11:0];
    assign isAbove     = sample.data > highLimit;
    assign isBelow     = sample.data < lowLimit;
    assign isInside    = (sample.data <= highRelease) && (sample.data >= lowRelease);

    // ------------------------------------------------------------------
    // Counter and sticky flag
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (eventClear) begin
            s_d.flag = 1'b0;
        end
        if (sample.valid) begin
            if (isAbove || isBelow) begin
                // At or past n, so lowering n mid-run cannot skip the flag
                if (s_q.cnt >= countCfg) begin
                    s_d.flag = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt + CNT_ONE;
                end
            end else if (isInside) begin
                s_d.cnt = CNT_ZERO;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign eventFlag = s_q.flag;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_flag_on_last_sample;
        sample.valid && (isAbove || isBelow) && s_q.cnt >= countCfg |=> eventFlag;
    endproperty
    a_flag_on_last_sample: assert property (p_flag_on_last_sample)
        else $error("flag not set after n+1 beyond samples");

    property p_no_early_flag;
        !eventFlag ##1 eventFlag |-> $past(s_q.cnt) >= $past(countCfg) && $past(sample.valid);
    endproperty
    a_no_early_flag: assert property (p_no_early_flag)
        else $error("flag set before n+1 beyond samples");

    property p_above_counts;
        sample.valid && sample.data > highLimit && s_q.cnt < countCfg
            |=> s_q.cnt == $past(s_q.cnt) + CNT_ONE;
    endproperty
    a_above_counts: assert property (p_above_counts)
        else $error("sample above high limit not counted");

    property p_below_counts;
        sample.valid && sample.data < lowLimit && s_q.cnt < countCfg
            |=> s_q.cnt == $past(s_q.cnt) + CNT_ONE;
    endproperty
    a_below_counts: assert property (p_below_counts)
        else $error("sample below low limit not counted");

    property p_band_holds;
        sample.valid && sample.data <= highLimit && sample.data >= lowLimit
            && !isInside |=> $stable(s_q.cnt);
    endproperty
    a_band_holds: assert property (p_band_holds)
        else $error("count changed inside hysteresis band");

    property p_inside_restarts;
        sample.valid && sample.data <= highLimit - hystAmt && highLimit >= hystAmt
            && sample.data >= lowLimit && lowSum[12] == 1'b0
            && sample.data >= lowSum[11:0] |=> s_q.cnt == CNT_ZERO;
    endproperty
    a_inside_restarts: assert property (p_inside_restarts)
        else $error("count not restarted inside release window");

    c_flag_raised: cover property (!eventFlag ##1 eventFlag);
    c_restart: cover property (s_q.cnt != CNT_ZERO ##1 s_q.cnt == CNT_ZERO);

endmodule

// ### hdl/wcthr_threshold_regs.sv
// Threshold, hysteresis and event-count register bank with channel 5 comparator
`timescale 1ns/1ps

// Summary of operation
// - High upper byte compares top eight result bits
// - High lower nibble compares result bits 3:0
// - Low lower nibble compares result bits 3:0
// - Hysteresis shifted left three, moves both release levels inside the limits
// - Flag after n+1 beyond-limit samples with no inside-window sample between
// - High limit fields reset to all ones
// - Low limit, hysteresis, count reset to zero
// - Hysteresis register: high nibble upper, hysteresis lower
// - Count register 0x36: low nibble, count field
// - Group order hysteresis, high, count, low
// - Channel 4 low upper byte at 0x33
module wcthr_threshold_regs
    import wcthr_pkg::*;
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          sys_rst,
    // Serial register port, decoded
    input  wire wcthr_regreq_t regReq,
    output logic [7:0]         regRdData,
    output logic               regRdValid,
    // Channel 5 samples and event flag
    input  wire wcthr_sample_t ch5Sample,
    input  wire logic          ch5EventClear,
    output logic               ch5EventFlag,
    // Fields for neighbouring channel groups
    output logic [7:0]         ch4LowLimitUpperByte,
    output logic [3:0]         ch6HighLimitLowerNibble,
    output logic [3:0]         ch6HystValue,
    output logic [7:0]         ch6HighLimitUpperByte
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    wcthr_bank_state_t s_q;
    wcthr_bank_state_t s_d;
    logic [11:0]       ch5HighLimit;
    logic [11:0]       ch5LowLimit;
    logic [3:0]        ch5HystValue;
    logic [3:0]        ch5ConsecutiveCount;

    // ------------------------------------------------------------------
    // Register write and read
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rdValid = regReq.rdEn;
        if (regReq.wrEn) begin
            unique case (regReq.addr)
                ADDR_CH4_LOW_UP:  s_d.regs.ch4LowUp  = regReq.wrData;
                ADDR_CH5_HYST:    s_d.regs.ch5Hyst   = regReq.wrData;
                ADDR_CH5_HIGH_UP: s_d.regs.ch5HighUp = regReq.wrData;
                ADDR_CH5_COUNT:   s_d.regs.ch5Count  = regReq.wrData;
                ADDR_CH5_LOW_UP:  s_d.regs.ch5LowUp  = regReq.wrData;
                ADDR_CH6_HYST:    s_d.regs.ch6Hyst   = regReq.wrData;
                ADDR_CH6_HIGH_UP: s_d.regs.ch6HighUp = regReq.wrData;
                default: begin
                    // Unmapped writes are dropped
                end
            endcase
        end
        if (regReq.rdEn) begin
            // Read sees the value held before a write in the same cycle
            unique case (regReq.addr)
                ADDR_CH4_LOW_UP:  s_d.rdData = s_q.regs.ch4LowUp;
                ADDR_CH5_HYST:    s_d.rdData = s_q.regs.ch5Hyst;
                ADDR_CH5_HIGH_UP: s_d.rdData = s_q.regs.ch5HighUp;
                ADDR_CH5_COUNT:   s_d.rdData = s_q.regs.ch5Count;
                ADDR_CH5_LOW_UP:  s_d.rdData = s_q.regs.ch5LowUp;
                ADDR_CH6_HYST:    s_d.rdData = s_q.regs.ch6Hyst;
                ADDR_CH6_HIGH_UP: s_d.rdData = s_q.regs.ch6HighUp;
                default:          s_d.rdData = RD_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q.regs    <= REGS_RESET;
            s_q.rdData  <= RD_UNMAPPED;
            s_q.rdValid <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Field extraction
    // ------------------------------------------------------------------
    assign ch5HighLimit        = {s_q.regs.ch5HighUp,
                                  s_q.regs.ch5Hyst[NIB_HI_MSB:NIB_HI_LSB]};
    assign ch5HystValue        = s_q.regs.ch5Hyst[NIB_LO_MSB:NIB_LO_LSB];
    assign ch5LowLimit         = {s_q.regs.ch5LowUp,
                                  s_q.regs.ch5Count[NIB_HI_MSB:NIB_HI_LSB]};
    assign ch5ConsecutiveCount = s_q.regs.ch5Count[NIB_LO_MSB:NIB_LO_LSB];

    assign regRdData               = s_q.rdData;
    assign regRdValid              = s_q.rdValid;
    assign ch4LowLimitUpperByte    = s_q.regs.ch4LowUp;
    assign ch6HighLimitLowerNibble = s_q.regs.ch6Hyst[NIB_HI_MSB:NIB_HI_LSB];
    assign ch6HystValue            = s_q.regs.ch6Hyst[NIB_LO_MSB:NIB_LO_LSB];
    assign ch6HighLimitUpperByte   = s_q.regs.ch6HighUp;

    // ------------------------------------------------------------------
    // Channel 5 comparator
    // ------------------------------------------------------------------
    wcthr_window_cmp u_ch5_cmp (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .highLimit  (ch5HighLimit),
        .lowLimit   (ch5LowLimit),
        .hystValue  (ch5HystValue),
        .countCfg   (ch5ConsecutiveCount),
        .sample     (ch5Sample),
        .eventClear (ch5EventClear),
        .eventFlag  (ch5EventFlag)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking

    property p_reset_high;
        sys_rst |=> ch5HighLimit == FULL_SCALE && ch6HighLimitUpperByte == RST_HIGH_UP
            && ch6HighLimitLowerNibble == RST_HYST[NIB_HI_MSB:NIB_HI_LSB];
    endproperty
    a_reset_high: assert property (p_reset_high)
        else $error("high limit not full scale after reset");

    property p_reset_low;
        sys_rst |=> ch5LowLimit == ZERO_SCALE && ch5HystValue == CNT_ZERO
            && ch5ConsecutiveCount == CNT_ZERO && ch4LowLimitUpperByte == RST_LOW_UP
            && ch6HystValue == CNT_ZERO;
    endproperty
    a_reset_low: assert property (p_reset_low)
        else $error("low limit or settings not zero after reset");

    property p_hyst_layout;
        disable iff (sys_rst)
        regReq.wrEn && regReq.addr == ADDR_CH5_HYST
            |=> ch5HighLimit[NIB_LO_MSB:NIB_LO_LSB] == $past(regReq.wrData[NIB_HI_MSB:NIB_HI_LSB])
            && ch5HystValue == $past(regReq.wrData[NIB_LO_MSB:NIB_LO_LSB]);
    endproperty
    a_hyst_layout: assert property (p_hyst_layout)
        else $error("hysteresis register fields misplaced");

    property p_count_layout;
        disable iff (sys_rst)
        regReq.wrEn && regReq.addr == ADDR_CH5_COUNT
            |=> ch5LowLimit[NIB_LO_MSB:NIB_LO_LSB] == $past(regReq.wrData[NIB_HI_MSB:NIB_HI_LSB])
            && ch5ConsecutiveCount == $past(regReq.wrData[NIB_LO_MSB:NIB_LO_LSB]);
    endproperty
    a_count_layout: assert property (p_count_layout)
        else $error("count register fields misplaced");

    property p_write_then_read_high;
        disable iff (sys_rst)
        regReq.wrEn && regReq.addr == ADDR_CH5_HIGH_UP ##1
            regReq.rdEn && regReq.addr == ADDR_CH5_HIGH_UP && !regReq.wrEn
            |=> regRdValid && regRdData == $past(regReq.wrData, 2);
    endproperty
    a_write_then_read_high: assert property (p_write_then_read_high)
        else $error("high upper byte readback mismatch");

    property p_ch4_readback;
        disable iff (sys_rst)
        regReq.rdEn && regReq.addr == ADDR_CH4_LOW_UP
            |=> regRdValid && regRdData == $past(ch4LowLimitUpperByte);
    endproperty
    a_ch4_readback: assert property (p_ch4_readback)
        else $error("channel 4 low upper byte readback mismatch");

    c_rd_hyst: cover property (disable iff (sys_rst)
        regReq.rdEn && regReq.addr == ADDR_CH5_HYST);
    c_flag: cover property (disable iff (sys_rst) ch5EventFlag);

endmodule

// ### verif/wcthr_threshold_regs_test.sv
// Self-checking testbench for the window comparator threshold register bank
`timescale 1ns/1ps

module wcthr_threshold_regs_test
    import wcthr_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals and instance
    // ------------------------------------------------------------------
    localparam int       DLY     = 2;
    localparam int       LIMIT   = 2000;
    logic                clk;
    logic                sysRst;
    wcthr_regreq_t       regReq;
    logic [7:0]          regRdData;
    logic                regRdValid;
    wcthr_sample_t       ch5Sample;
    logic                ch5EventClear;
    logic                ch5EventFlag;
    logic [7:0]          ch4Out;
    logic [3:0]          ch6Nib;
    logic [3:0]          ch6Hyst;
    logic [7:0]          ch6Up;
    int                  errors  = 0;
    int                  checks  = 0;
    int                  cycles  = 0;
    logic [7:0]          addrTab [7] = '{8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39};
    logic [7:0]          rstTab  [7] = '{8'h00, 8'hf0, 8'hff, 8'h00, 8'h00, 8'hf0, 8'hff};
    logic [7:0]          wrTab   [7] = '{8'h5a, 8'h9c, 8'h3e, 8'hc7, 8'h61, 8'ha4, 8'h1b};

    wcthr_threshold_regs dut (
        .clk                     (clk),
        .sys_rst                 (sysRst),
        .regReq                  (regReq),
        .regRdData               (regRdData),
        .regRdValid              (regRdValid),
        .ch5Sample               (ch5Sample),
        .ch5EventClear           (ch5EventClear),
        .ch5EventFlag            (ch5EventFlag),
        .ch4LowLimitUpperByte    (ch4Out),
        .ch6HighLimitLowerNibble (ch6Nib),
        .ch6HystValue            (ch6Hyst),
        .ch6HighLimitUpperByte   (ch6Up)
    );

    initial clk = 1'b0;
    always #25 clk = ~clk;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            finish_test();
        end
    end

    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Every operation strobes one cycle then idles one, so no strobe is set twice in a step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regReq.wrEn   = 1'b1;
        regReq.addr   = a;
        regReq.wrData = d;
        @(posedge clk);
        #DLY;
        regReq.wrEn   = 1'b0;
        @(posedge clk);
        #DLY;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        regReq.rdEn = 1'b1;
        regReq.addr = a;
        @(posedge clk);
        #DLY;
        regReq.rdEn = 1'b0;
        chk("read valid", 12'h001, {11'h0, regRdValid});
        chk($sformatf("read data at %h", a), {4'h0, exp}, {4'h0, regRdData});
        @(posedge clk);
        #DLY;
        chk("read valid drop", 12'h000, {11'h0, regRdValid});
    endtask

    task automatic smp(input logic [11:0] d);
        ch5Sample.valid = 1'b1;
        ch5Sample.data  = d;
        @(posedge clk);
        #DLY;
        ch5Sample.valid = 1'b0;
        @(posedge clk);
        #DLY;
    endtask

    task automatic clr();
        ch5EventClear = 1'b1;
        @(posedge clk);
        #DLY;
        ch5EventClear = 1'b0;
        @(posedge clk);
        #DLY;
    endtask

    task automatic flag(input logic exp);
        chk("event flag", {11'h0, exp}, {11'h0, ch5EventFlag});
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        sysRst        = 1'b1;
        regReq        = '0;
        ch5Sample     = '0;
        ch5EventClear = 1'b0;
        repeat (12) @(posedge clk);
        #DLY;
        sysRst = 1'b0;
        chk("valid after reset", 12'h000, {11'h0, regRdValid});
        flag(1'b0);
        // Reset values, then unmapped read
        for (int i = 0; i < 7; i++) rd(addrTab[i], rstTab[i]);
        rd(8'h3a, RD_UNMAPPED);
        chk("ch4 low upper", 12'h000, {4'h0, ch4Out});
        chk("ch6 high nibble", 12'h00f, {8'h0, ch6Nib});
        chk("ch6 hysteresis", 12'h000, {8'h0, ch6Hyst});
        chk("ch6 high upper", 12'h0ff, {4'h0, ch6Up});
        // All written before any read back, so decode aliasing shows
        for (int i = 0; i < 7; i++) wr(addrTab[i], wrTab[i]);
        wr(8'h32, 8'h77);
        for (int i = 0; i < 7; i++) rd(addrTab[i], wrTab[i]);
        rd(8'h32, RD_UNMAPPED);
        chk("ch4 out", {4'h0, wrTab[0]}, {4'h0, ch4Out});
        chk("ch6 nibble out", {8'h0, wrTab[5][7:4]}, {8'h0, ch6Nib});
        chk("ch6 hyst out", {8'h0, wrTab[5][3:0]}, {8'h0, ch6Hyst});
        chk("ch6 upper out", {4'h0, wrTab[6]}, {4'h0, ch6Up});
        // Back to back: write, read, then read beside a write
        regReq.wrEn   = 1'b1;
        regReq.addr   = ADDR_CH5_HIGH_UP;
        regReq.wrData = 8'hd2;
        @(posedge clk);
        #DLY;
        regReq.wrEn   = 1'b0;
        regReq.rdEn   = 1'b1;
        @(posedge clk);
        #DLY;
        chk("back to back read", 12'h0d2, {4'h0, regRdData});
        regReq.wrEn   = 1'b1;
        regReq.addr   = ADDR_CH4_LOW_UP;
        regReq.wrData = 8'h3c;
        @(posedge clk);
        #DLY;
        regReq.wrEn   = 1'b0;
        regReq.rdEn   = 1'b0;
        chk("read beside write", {4'h0, wrTab[0]}, {4'h0, regRdData});
        chk("ch4 after write", 12'h03c, {4'h0, ch4Out});
        @(posedge clk);
        #DLY;
        // High 0x805, low 0x103, no hysteresis, n = 2
        wr(ADDR_CH5_HIGH_UP, 8'h80);
        wr(ADDR_CH5_HYST, 8'h50);
        wr(ADDR_CH5_LOW_UP, 8'h10);
        wr(ADDR_CH5_COUNT, 8'h32);
        clr();
        repeat (4) smp(12'h805);
        flag(1'b0);
        smp(12'h806);
        smp(12'h806);
        smp(12'h400);
        smp(12'h806);
        smp(12'h806);
        flag(1'b0);
        smp(12'h806);
        flag(1'b1);
        clr();
        flag(1'b0);
        // Low side with n = 0
        wr(ADDR_CH5_COUNT, 8'h30);
        smp(12'h103);
        flag(1'b0);
        smp(12'h102);
        flag(1'b1);
        clr();
        // Hysteresis 2 gives a release window 0x10 inside each limit, n = 1
        wr(ADDR_CH5_HYST, 8'h52);
        wr(ADDR_CH5_COUNT, 8'h31);
        smp(12'h806);
        smp(12'h7fa);
        smp(12'h806);
        flag(1'b1);
        clr();
        // Count holds at or past n after a set, so restart it first
        smp(12'h400);
        smp(12'h806);
        smp(12'h7f5);
        smp(12'h806);
        flag(1'b0);
        // Top byte decides with n = 0
        wr(ADDR_CH5_COUNT, 8'h30);
        clr();
        smp(12'h7ff);
        flag(1'b0);
        smp(12'h900);
        flag(1'b1);
        finish_test();
    end

endmodule
